/* File: efab_pkg.sv */
// How it works
// R1: one 128 KB array behind one AHB slave
// R2: 32-bit program bus, 64-bit read bus
// R3: array clock divided, at most 26.3 MHz
// R4: array pulse long enough for 80 ns access
// R5: array clock gated, restarts on demand
// R6: every array read fetches 64 bits, buffered unless it has a double error
// R7: buffer hit returns half word, no array read
// R8: config accesses map one for one
// R9: program write waits for grant, then completes
// R10: next program op waits for grant again
// R11: four sectors in one 128 KB read space
// R12: 512-byte config region, read and write
// R13: sectors read-only, write gets error
// R14: no programming of array from AHB
// R15: boot controller also reads the array
// R16: secded on read data, double error errors
// R17: buffer cleared on reset and program write
package efab_pkg;
  // timing figures and the cycle counts derived from them
  localparam int CORE_CLK_MHZ = 200;
  localparam int CORE_PERIOD_NS = 5;
  localparam int ARR_CLK_MAX_KHZ = 26300;
  localparam int ARR_ACCESS_NS = 80;
  localparam int ARR_MIN_PER_CYC =
    (CORE_CLK_MHZ * 1000 + ARR_CLK_MAX_KHZ - 1) / ARR_CLK_MAX_KHZ;
  localparam int ARR_ACC_CYC = (ARR_ACCESS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int ARR_PER_CYC = (ARR_ACC_CYC > ARR_MIN_PER_CYC) ? ARR_ACC_CYC : ARR_MIN_PER_CYC;
  localparam int PCNT_W = 5;
  localparam logic [PCNT_W-1:0] PCNT_LAST = PCNT_W'(ARR_PER_CYC - 1);
  localparam logic [PCNT_W-1:0] PCNT_HI = PCNT_W'(ARR_PER_CYC / 2);
  // address map
  localparam int REGION_BIT = 17;
  localparam int OFS_W = 17;
  localparam int CFG_ADDR_W = 9;
  localparam int RWORD_W = 14;
  localparam int CWORD_W = 7;
  localparam logic [OFS_W-1:0] SECT1_OFS = 17'h02000;
  localparam logic [OFS_W-1:0] SECT2_OFS = 17'h10000;
  localparam logic [OFS_W-1:0] SECT3_OFS = 17'h1e000;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam int ECC_W = 8;
  // controller states
  typedef enum logic [2:0] {S_IDLE, S_RD, S_CG, S_CP, S_ERR} efab_state_t;
  // ahb address phase request
  typedef struct packed {
    logic sel;
    logic ready;
    logic [1:0] trans;
    logic write;
    logic [31:0] addr;
  } efab_ahb_req_t;
  // ahb answer
  typedef struct packed {
    logic readyout;
    logic resp;
    logic [31:0] rdata;
  } efab_ahb_rsp_t;
  // boot controller read port
  typedef struct packed {
    logic req;
    logic [OFS_W-1:0] addr;
  } efab_boot_req_t;
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] data;
  } efab_boot_rsp_t;
  // array read bus
  typedef struct packed {
    logic req;
    logic [RWORD_W-1:0] addr;
  } efab_rbus_t;
  typedef struct packed {
    logic [63:0] data;
    logic [ECC_W-1:0] ecc;
  } efab_rdata_t;
  // array program bus
  typedef struct packed {
    logic req;
    logic write;
    logic [CWORD_W-1:0] addr;
    logic [31:0] wdata;
  } efab_cbus_t;
endpackage : efab_pkg

/* File: efab_ctrl.sv */
module efab_ctrl import efab_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input efab_ahb_req_t i_ahb,
  input wire logic [31:0] i_hwdata,
  output efab_ahb_rsp_t o_ahb,
  input efab_boot_req_t i_boot,
  output efab_boot_rsp_t o_boot,
  output logic o_arr_clk,
  input wire logic i_arr_clk_req,
  output efab_rbus_t o_rbus,
  input efab_rdata_t i_rdata,
  output efab_cbus_t o_cbus,
  input wire logic i_c_grant,
  input wire logic [31:0] i_c_rdata,
  output logic [1:0] o_rd_sector
);

  // 64-bit word index of a read-space offset
  function automatic logic [RWORD_W-1:0] word_of(
    input logic [OFS_W-1:0] a);
    return a[OFS_W-1:3];
  endfunction : word_of

  // pick the addressed 32-bit half
  function automatic logic [31:0] half_of(
    input logic [63:0] w,
    input logic hi);
    return hi ? w[63:32] : w[31:0];
  endfunction : half_of

  // sector index in address order
  function automatic logic [1:0] sector_of(
    input logic [OFS_W-1:0] a);
    logic [1:0] s;
    s = 2'h0;
    if (a >= SECT3_OFS) s = 2'h3;
    else if (a >= SECT2_OFS) s = 2'h2;
    else if (a >= SECT1_OFS) s = 2'h1;
    return s;
  endfunction : sector_of

  // hamming(71,64) plus overall parity; returns {ded, fixed data}
  function automatic logic [64:0] secded(
    input logic [63:0] d,
    input logic [ECC_W-1:0] c);
    logic [6:0] syn;
    logic par;
    logic [63:0] fx;
    int k;
    syn = c[6:0];
    par = ^{d, c};
    fx = d;
    k = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (d[k]) syn = syn ^ p[6:0];
        k = k + 1;
      end
    end
    k = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        // single error only when overall parity is odd
        if (par && syn == p[6:0]) fx[k] = ~d[k];
        k = k + 1;
      end
    end
    return {(syn != 7'h00) && !par, fx};
  endfunction : secded

  efab_state_t state; // controller state
  logic owner_boot; // current access is from the boot port
  logic [OFS_W-1:0] req_addr; // offset of current access
  logic req_write; // current access is a write
  logic buf_valid; // read buffer holds a word
  logic [RWORD_W-1:0] buf_tag; // word index of buffered data
  logic [63:0] buf_data; // buffered corrected word
  logic active; // array clock pulse in progress
  logic ours; // pulse belongs to a controller access
  logic [PCNT_W-1:0] pcnt; // cycle within current pulse

  logic ahb_take;
  logic is_r;
  logic [OFS_W-1:0] lofs;
  logic cfg_bad;
  logic hit;
  logic boot_take;
  logic boot_hit;
  logic need_pulse;
  logic start;
  logic pulse_end;
  logic our_end;
  logic [64:0] chk;
  logic ded;
  logic [31:0] sel32;

  // request decode
  always_comb begin
    lofs = i_ahb.addr[OFS_W-1:0];
    is_r = i_ahb.addr[REGION_BIT]; // R11
    cfg_bad = |lofs[OFS_W-1:CFG_ADDR_W]; // R12
    ahb_take = (state == S_IDLE) && i_ahb.sel && i_ahb.ready // R1
      && i_ahb.trans[HTRANS_ACTIVE_BIT];
    hit = buf_valid && (buf_tag == word_of(lofs)); // R7
    // ahb wins; a held boot request is not retaken on its ack cycle
    boot_take = (state == S_IDLE) && !ahb_take && i_boot.req
      && !o_boot.ack; // R15
    boot_hit = buf_valid && (buf_tag == word_of(i_boot.addr));
  end

  // array clock control
  always_comb begin
    need_pulse = (state == S_RD) || (state == S_CP);
    // clock only runs for an access or when the array asks
    start = !active && (need_pulse || i_arr_clk_req); // R5
    pulse_end = active && (pcnt == PCNT_LAST); // R4
    our_end = pulse_end && ours;
  end

  // read data check and half select
  always_comb begin
    chk = secded(i_rdata.data, i_rdata.ecc); // R16
    ded = chk[64];
    sel32 = half_of(chk[63:0], req_addr[2]);
  end

  // array clock generator; pulse is high for half the period
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      active <= 1'b0;
      ours <= 1'b0;
      pcnt <= '0;
      o_arr_clk <= 1'b0;
    end else if (start) begin
      // restart on any core cycle, no wait for a free-running phase
      active <= 1'b1; // R5
      ours <= need_pulse;
      pcnt <= '0;
      o_arr_clk <= 1'b1; // R3
    end else if (pulse_end) begin
      active <= 1'b0;
      ours <= 1'b0;
      o_arr_clk <= 1'b0;
    end else if (active) begin
      pcnt <= pcnt + 5'h01;
      o_arr_clk <= (pcnt + 5'h01) < PCNT_HI; // R3
    end
  end

  // main sequencer and bus answers
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= S_IDLE;
      owner_boot <= 1'b0;
      req_addr <= '0;
      req_write <= 1'b0;
      o_ahb <= '{readyout: 1'b1, resp: 1'b0, rdata: 32'h0};
      o_boot <= '0;
    end else begin
      o_boot.ack <= 1'b0;
      case (state)
        S_IDLE: begin
          o_ahb.resp <= 1'b0;
          // a boot miss holds ahb off, else its address phase would be lost
          o_ahb.readyout <= !boot_take || boot_hit;
          if (ahb_take) begin
            owner_boot <= 1'b0;
            req_addr <= lofs;
            req_write <= i_ahb.write;
            if (is_r && i_ahb.write) begin
              // sectors are read-only from this side
              state <= S_ERR; // R13 R14
              o_ahb.readyout <= 1'b0;
              o_ahb.resp <= 1'b1;
            end else if (is_r && hit) begin
              // zero wait hit from the buffer
              o_ahb.rdata <= half_of(buf_data, lofs[2]); // R7
            end else if (is_r) begin
              state <= S_RD; // R6
              o_ahb.readyout <= 1'b0;
            end else if (cfg_bad) begin
              // outside the config region
              state <= S_ERR; // R12
              o_ahb.readyout <= 1'b0;
              o_ahb.resp <= 1'b1;
            end else begin
              state <= S_CG; // R8
              o_ahb.readyout <= 1'b0;
            end
          end else if (boot_take) begin
            owner_boot <= 1'b1;
            req_addr <= i_boot.addr;
            req_write <= 1'b0;
            if (boot_hit) begin
              o_boot.ack <= 1'b1; // R15
              o_boot.err <= 1'b0;
              o_boot.data <= half_of(buf_data, i_boot.addr[2]);
            end else begin
              state <= S_RD;
            end
          end
        end
        S_RD: begin
          if (our_end) begin
            state <= S_IDLE;
            if (owner_boot) begin
              o_ahb.readyout <= 1'b1; // ahb may proceed again
              o_boot.ack <= 1'b1;
              o_boot.err <= ded;
              o_boot.data <= sel32;
            end else if (ded) begin
              // uncorrectable: two-cycle error answer
              state <= S_ERR; // R16
              o_ahb.resp <= 1'b1;
            end else begin
              o_ahb.readyout <= 1'b1; // R6
              o_ahb.rdata <= sel32;
            end
          end
        end
        S_CG: begin
          // hold the transfer until the array grants
          if (i_c_grant) state <= S_CP; // R9 R10
        end
        S_CP: begin
          if (our_end) begin
            // write released; array carries on internally
            state <= S_IDLE; // R9
            o_ahb.readyout <= 1'b1;
            if (!req_write) o_ahb.rdata <= i_c_rdata; // R8
          end
        end
        S_ERR: begin
          state <= S_IDLE;
          o_ahb.readyout <= 1'b1;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // read buffer; a double error is never buffered
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      buf_valid <= 1'b0; // R17
      buf_tag <= '0;
      buf_data <= '0;
    end else if (state == S_RD && our_end && !ded) begin
      buf_valid <= 1'b1; // R6 R16
      buf_tag <= word_of(req_addr);
      buf_data <= chk[63:0];
    end else if (state == S_CP && start && req_write) begin
      // contents may change under a program write
      buf_valid <= 1'b0; // R17
    end
  end

  // read bus drive, one request per our pulse
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rbus <= '0;
      o_rd_sector <= 2'h0;
    end else if (state == S_RD && start) begin
      o_rbus.req <= 1'b1; // R2
      o_rbus.addr <= word_of(req_addr);
      o_rd_sector <= sector_of(req_addr); // R11
    end else if (pulse_end) begin
      o_rbus.req <= 1'b0;
    end
  end

  // program bus drive; fields settle while waiting for grant
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_cbus <= '0;
    end else begin
      if (state == S_CG) begin
        o_cbus.write <= req_write; // R8
        o_cbus.addr <= req_addr[CFG_ADDR_W-1:2];
        o_cbus.wdata <= i_hwdata; // R2
      end
      if (state == S_CP && start) o_cbus.req <= 1'b1; // R10
      else if (pulse_end) o_cbus.req <= 1'b0;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  property p_hit;
    ahb_take && is_r && !i_ahb.write && hit |=> o_ahb.readyout && !o_ahb.resp;
  endproperty
  a_hit: assert property (p_hit) else $error("buffer hit stalled"); // R7

  property p_miss;
    ahb_take && is_r && !i_ahb.write && !hit |=> !o_ahb.readyout && state == S_RD;
  endproperty
  a_miss: assert property (p_miss) else $error("miss not sent to array"); // R6

  property p_rowr;
    ahb_take && is_r && i_ahb.write
      |=> (o_ahb.resp && !o_ahb.readyout) ##1 (o_ahb.resp && o_ahb.readyout);
  endproperty
  a_rowr: assert property (p_rowr) else $error("sector write not refused"); // R13

  property p_grant;
    state == S_CG && !i_c_grant |=> state == S_CG && !o_cbus.req;
  endproperty
  a_grant: assert property (p_grant) else $error("program op without grant"); // R10

  property p_wdone;
    state == S_CP && req_write && our_end |=> o_ahb.readyout && !o_cbus.req;
  endproperty
  a_wdone: assert property (p_wdone) else $error("write not released"); // R9

  property p_gate;
    !active |-> !o_arr_clk;
  endproperty
  a_gate: assert property (p_gate) else $error("array clock not gated"); // R5

  property p_pulse;
    $rose(o_arr_clk) |-> o_arr_clk [*8] ##1 !o_arr_clk;
  endproperty
  a_pulse: assert property (p_pulse) else $error("array pulse width wrong"); // R4
  property p_ded;
    state == S_RD && our_end && ded && !owner_boot
      |=> (o_ahb.resp && !o_ahb.readyout) ##1 (o_ahb.resp && o_ahb.readyout);
  endproperty
  a_ded: assert property (p_ded) else $error("double error not reported"); // R16

  property p_boot;
    boot_take && boot_hit |=> o_boot.ack && !o_boot.err;
  endproperty
  a_boot: assert property (p_boot) else $error("boot hit not answered"); // R15

  property p_inval;
    o_cbus.req && o_cbus.write |-> !buf_valid;
  endproperty
  a_inval: assert property (p_inval) else $error("buffer kept over write"); // R17

endmodule : efab_ctrl

/* File: efab_arr_model.sv */
// behavioural array macro on the far side of the controller
module efab_arr_model import efab_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_arr_clk,
  input efab_rbus_t i_rbus,
  input efab_cbus_t i_cbus,
  input wire logic [1:0] i_err_mode,
  input wire logic i_block,
  output efab_rdata_t o_rdata,
  output logic o_c_grant,
  output logic [31:0] o_c_rdata,
  output logic o_clk_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cfg [0:127]; // config words
  logic [7:0] busy; // internal program op countdown
  logic clk_q; // array clock one core cycle ago
  logic [63:0] word; // stored word for the read address
  logic [63:0] flip; // injected bit errors
  // hamming over positions 1..71 plus overall parity
  function automatic logic [7:0] ecc_of(input logic [63:0] d);
    logic [71:0] cw;
    logic [7:0] e;
    int j;
    cw = '0;
    e = '0;
    j = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 7; k++) begin
      for (int p = 1; p < 72; p++) begin
        if (p[k]) e[k] = e[k] ^ cw[p];
      end
    end
    e[7] = ^{d, e[6:0]};
    return e;
  endfunction : ecc_of
  assign word = {~32'(i_rbus.addr), 32'(i_rbus.addr) ^ 32'h5a5a0000};
  assign flip = (i_err_mode == 2'h2) ? 64'h220 : ((i_err_mode == 2'h1) ? 64'h20 : 64'h0);
  // released read bus shows the inverse so stale values never pass
  assign o_rdata = i_rbus.req ? {word ^ flip, ecc_of(word)} : {~word, 8'hff};
  assign o_c_rdata = i_cbus.req ? cfg[i_cbus.addr] : ~cfg[i_cbus.addr];
  assign o_c_grant = (busy == 8'h00) && !i_block;
  assign o_clk_req = (busy != 8'h00);
  // program write lands on pulse start, then the array stays busy
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy <= 8'h00;
      clk_q <= 1'b0;
      // config words start cleared; one process owns them
      for (int i = 0; i < 128; i++) begin
        cfg[i] <= 32'h0;
      end
    end else begin
      clk_q <= i_arr_clk;
      if (i_arr_clk && !clk_q && i_cbus.req && i_cbus.write) begin
        cfg[i_cbus.addr] <= i_cbus.wdata;
        busy <= 8'h28;
      end else if (busy != 8'h00) begin
        busy <= busy - 8'h01;
      end
    end
  end
endmodule : efab_arr_model

/* File: efab_ctrl_tb.sv */
module efab_ctrl_tb import efab_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic h_sel = 1'b0;
  logic h_write = 1'b0;
  logic [1:0] h_trans = 2'h0;
  logic [31:0] h_addr = 32'h0;
  logic [31:0] h_wdata = 32'h0;
  efab_ahb_req_t ahb_req;
  efab_ahb_rsp_t rsp;
  efab_boot_req_t boot = '0;
  efab_boot_rsp_t brsp;
  efab_rbus_t rbus;
  efab_rdata_t rdata;
  efab_cbus_t cbus;
  logic arr_clk, clk_req, grant;
  logic block = 1'b0; // holds grant low on demand
  logic [1:0] err_mode = 2'h0;
  logic [1:0] sector;
  logic [31:0] c_rdata, rd;
  logic resp;
  int fail_count = 0;
  int cmp_count = 0;
  int pulses = 0; // array clock pulses seen
  int waits; // cycles until the answer
  int p;
  // hready in follows our only target
  assign ahb_req = '{sel: h_sel, ready: rsp.readyout, trans: h_trans, write: h_write, addr: h_addr};
  always #2.5 clk = ~clk;
  always @(posedge arr_clk) pulses++;
  efab_ctrl u_dut (.i_core_clk(clk), .i_resetn(rstn), .i_ahb(ahb_req), .i_hwdata(h_wdata), .o_ahb(rsp),
    .i_boot(boot), .o_boot(brsp), .o_arr_clk(arr_clk), .i_arr_clk_req(clk_req), .o_rbus(rbus),
    .i_rdata(rdata), .o_cbus(cbus), .i_c_grant(grant), .i_c_rdata(c_rdata), .o_rd_sector(sector));
  efab_arr_model u_arr (.i_core_clk(clk), .i_resetn(rstn), .i_arr_clk(arr_clk), .i_rbus(rbus),
    .i_cbus(cbus), .i_err_mode(err_mode), .i_block(block), .o_rdata(rdata), .o_c_grant(grant),
    .o_c_rdata(c_rdata), .o_clk_req(clk_req));
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // expected half word of the stored pattern
  function automatic logic [31:0] exp_rd(input logic [16:0] ofs);
    logic [63:0] w;
    w = {~32'(ofs[16:3]), 32'(ofs[16:3]) ^ 32'h5a5a0000};
    return ofs[2] ? w[63:32] : w[31:0];
  endfunction : exp_rd
  // address phase only; caller keeps the target idle first
  task ahb_start(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(negedge clk);
    h_sel = 1'b1;
    h_trans = 2'h2;
    h_write = wr;
    h_addr = a;
    h_wdata = wd;
    @(negedge clk);
    h_sel = 1'b0;
    h_trans = 2'h0;
  endtask : ahb_start
  task ahb_end();
    waits = 0;
    while (rsp.readyout !== 1'b1 && waits < 400) begin
      @(negedge clk);
      waits++;
    end
    rd = rsp.rdata;
    resp = rsp.resp;
  endtask : ahb_end
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    ahb_start(wr, a, wd);
    ahb_end();
  endtask : ahb
  task t_reset();
    chk_bit(rsp.readyout, 1'b1);
    chk_bit(arr_clk, 1'b0);
  endtask : t_reset
  task t_read_buf();
    p = pulses;
    ahb(1'b0, 32'h22008, 32'h0);
    chk_word(rd, exp_rd(17'h02008));
    chk_bit(pulses == p + 1, 1'b1);
    ahb(1'b0, 32'h2200c, 32'h0);
    chk_word(rd, exp_rd(17'h0200c));
    chk_bit(pulses == p + 1 && waits == 0, 1'b1);
  endtask : t_read_buf
  task t_sectors();
    logic [16:0] ofs [6];
    logic [1:0] sec [6];
    ofs = '{17'h01ffc, 17'h02000, 17'h0fffc, 17'h10000, 17'h1e000, 17'h1fffc};
    sec = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, {15'h1, ofs[i]}, 32'h0);
      chk_word(rd, exp_rd(ofs[i]));
      chk_word({30'h0, sector}, {30'h0, sec[i]});
    end
  endtask : t_sectors
  task t_ro();
    p = pulses;
    ahb(1'b1, 32'h20010, 32'h12345678);
    chk_bit(resp, 1'b1);
    chk_bit(pulses == p, 1'b1);
    ahb(1'b0, 32'h20010, 32'h0);
    chk_word(rd, exp_rd(17'h00010));
  endtask : t_ro
  task t_cfg();
    block = 1'b1;
    ahb_start(1'b1, 32'h40, 32'h13579bdf);
    repeat (30) @(negedge clk);
    chk_bit(rsp.readyout, 1'b0);
    chk_bit(cbus.req, 1'b0);
    block = 1'b0;
    ahb_end();
    chk_bit(resp, 1'b0);
    ahb(1'b1, 32'h1fc, 32'h2468ace0);
    chk_bit(waits > 39, 1'b1);
    ahb(1'b0, 32'h40, 32'h0);
    chk_word(rd, 32'h13579bdf);
    ahb(1'b0, 32'h1fc, 32'h0);
    chk_word(rd, 32'h2468ace0);
    ahb(1'b0, 32'h200, 32'h0);
    chk_bit(resp, 1'b1);
  endtask : t_cfg
  task t_inval();
    repeat (60) @(negedge clk);
    p = pulses;
    ahb(1'b0, 32'h20010, 32'h0);
    chk_bit(pulses > p, 1'b1);
    chk_word(rd, exp_rd(17'h00010));
  endtask : t_inval
  task t_ecc();
    err_mode = 2'h1;
    ahb(1'b0, 32'h20100, 32'h0);
    chk_word(rd, exp_rd(17'h00100));
    chk_bit(resp, 1'b0);
    err_mode = 2'h2;
    ahb(1'b0, 32'h20204, 32'h0);
    chk_bit(resp, 1'b1);
    err_mode = 2'h0;
    p = pulses;
    ahb(1'b0, 32'h20200, 32'h0);
    chk_bit(pulses == p + 1, 1'b1);
    chk_word(rd, exp_rd(17'h00200));
  endtask : t_ecc
  // boot port read; request dropped in the ack cycle
  task boot_rd(input logic [16:0] a);
    @(negedge clk);
    boot = '{req: 1'b1, addr: a};
    waits = 0;
    do begin
      @(negedge clk);
      waits++;
    end while (brsp.ack !== 1'b1 && waits < 200);
    boot.req = 1'b0;
  endtask : boot_rd
  task t_boot();
    boot_rd(17'h03008);
    chk_word(brsp.data, exp_rd(17'h03008));
    chk_bit(brsp.err, 1'b0);
    p = pulses;
    boot_rd(17'h0300c);
    chk_word(brsp.data, exp_rd(17'h0300c));
    chk_bit(pulses == p && waits == 1, 1'b1);
    ahb(1'b0, 32'h2300c, 32'h0);
    chk_word(rd, exp_rd(17'h0300c));
    chk_bit(pulses == p, 1'b1);
    err_mode = 2'h2;
    boot_rd(17'h04000);
    err_mode = 2'h0;
    chk_bit(brsp.err, 1'b1);
  endtask : t_boot
  // mid-run reset must drop the buffered word
  task t_rereset();
    @(negedge clk);
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    chk_bit(arr_clk, 1'b0);
    rstn = 1'b1;
    p = pulses;
    ahb(1'b0, 32'h2300c, 32'h0);
    chk_bit(pulses == p + 1, 1'b1);
    chk_word(rd, exp_rd(17'h0300c));
  endtask : t_rereset
  task finish_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // main sequence; reset held for 20 cycles
  initial begin
    repeat (20) @(negedge clk);
    t_reset();
    rstn = 1'b1;
    t_read_buf();
    t_sectors();
    t_ro();
    t_cfg();
    t_inval();
    t_ecc();
    t_boot();
    t_rereset();
    finish_test();
  end
  // watchdog well past the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule : efab_ctrl_tb
